// [bench/fpd_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module fpd_monitor import fpd_pkg::*; (
	input wire logic       mclk_i,
	input wire logic       nrst_i,
	input wire logic       cfg_valid,
	input wire logic [5:0] cfg_in_cnt,
	input wire logic [5:0] cfg_out_cnt,
	input wire logic       diag_req,
	input wire logic [4:0] diag_idx,
	input wire logic [7:0] diag_data,
	input wire logic [4:0] diag_len
);
	// One domain for every check
	default clocking mon_cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);

	// Telegram length and header
	AST_LEN: assert property (diag_req |=> diag_len == 5'h10 || diag_len == 5'h14)
		else $error("diag length not 16 or 20");
	AST_HEADER: assert property (diag_req && diag_idx == 5'h06 |=> diag_data == 8'(diag_len) - 8'h06)
		else $error("header byte off length");
	AST_TAIL: assert property (diag_req && diag_idx >= 5'h14 |=> diag_data == 8'h00)
		else $error("byte past end not zero");
	// Fixed status bits; diag data held without a request
	AST_STD0: assert property (diag_req && diag_idx == 5'h00 |=> !diag_data[5] && !diag_data[0])
		else $error("status byte 0 fixed bits set");
	AST_STD1: assert property (diag_req && diag_idx == 5'h01 |=> diag_data[2])
		else $error("status byte 1 bit 2 low");
	AST_HOLD: assert property (!diag_req |=> $stable(diag_data))
		else $error("diag data moved unasked");
	// Configuration error numbers, one cycle after the check
	AST_CFG_IN: assert property (cfg_valid && cfg_in_cnt > 6'h20 ##1 diag_req && diag_idx == 5'h08
		|=> diag_data[7:4] == 4'h1) else $error("input overflow not error 1");
	AST_CFG_OUT: assert property (cfg_valid && cfg_in_cnt <= 6'h20 && cfg_out_cnt > 6'h18
		##1 diag_req && diag_idx == 5'h08 |=> diag_data[7:4] == 4'h2) else $error("output overflow not error 2");
endmodule : fpd_monitor
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define TB_CHECK(g, x) begin n_checks++; if ((g) !== (x)) begin n_errors++; $display("BAD %0t got %h want %h", $time, g, x); end end
module tb_top import fpd_pkg::*; ;
	logic            mclk_i = 1'b0;
	logic            nrst_i = 1'b0;
	logic            pv = 1'b0, pl = 1'b0, cv = 1'b0, cb = 1'b0, dr = 1'b0, fen = 1'b0, mof = 1'b0, lng = 1'b0;
	logic            chk = 1'b0, csel = 1'b0, nv_er, nv_wr;
	logic [7:0]      pd = 8'h00, tnr = 8'h00, tcf = 8'h00, tof = 8'h00, ma = 8'h00, dd;
	logic [5:0]      ci = 6'h00, co = 6'h00, sf = 6'h00;
	logic [4:0]      di = 5'h00;
	logic [31:0]     rep = 32'h0, img, got, r1;
	logic [63:0]     sw = 64'h0, ent;
	logic [3:0]      d_in, d_out, d_cnt;
	logic [7:0][7:0] d_ids;
	logic [2:0]      rp = 3'h0;
	logic [15:0]     e;
	logic [63:0]     exp_q[$];
	logic [7:0]      t[$];
	logic [7:0]      ok_id[8] = '{8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h22};
	int              n_errors = 0, n_checks = 0;

	always #20 mclk_i = ~mclk_i;

	fpd_if fpd_if_i ();
	fpd_master fpd_master_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(fpd_if_i.master), .prm_valid_i(pv),
		.prm_data_i(pd), .prm_last_i(pl), .cfg_valid_i(cv), .cfg_in_i(ci), .cfg_out_i(co), .cfg_bad_i(cb),
		.diag_req_i(dr), .diag_idx_i(di), .diag_data_o(dd), .diag_len_o(), .in_image_o(img));
	fpd_slave #(.FILT_CYC(10)) fpd_slave_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(fpd_if_i.slave),
		.repeater_i(rep), .filter_en_i(fen), .term_no_response_i(tnr), .term_configured_i(tcf),
		.term_out_fail_i(tof), .main_out_fail_i(mof), .term_switch_i(sw), .long_diag_i(lng), .master_addr_i(ma),
		.std_flags_i(sf), .nv_erase_o(nv_er), .nv_write_o(nv_wr), .def_in_bytes_o(d_in),
		.def_out_bytes_o(d_out), .def_ids_o(d_ids), .def_id_cnt_o(d_cnt));
	fpd_monitor fpd_monitor_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .cfg_valid(fpd_if_i.cfg_valid),
		.cfg_in_cnt(fpd_if_i.cfg_in_cnt), .cfg_out_cnt(fpd_if_i.cfg_out_cnt), .diag_req(fpd_if_i.diag_req),
		.diag_idx(fpd_if_i.diag_idx), .diag_data(fpd_if_i.diag_data), .diag_len(fpd_if_i.diag_len));

	// Scoreboard: oldest note against each result shown
	always @(posedge mclk_i) begin
		rp <= {rp[1:0], dr};
		if (rp[2] || chk || nv_wr || nv_er) begin
			got = rp[2] ? {24'h0, dd} : chk ? (csel ? {24'h0, d_in, d_out} : img)
				: {nv_er, nv_wr, 2'b00, d_cnt, 8'h00, d_ids[1], d_ids[0]};
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("BAD %0t result not expected", $time);
			end else begin
				ent = exp_q.pop_front();
				`TB_CHECK(got & ent[63:32], ent[31:0])
			end
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : tick

	task automatic note(input logic [31:0] m, v);
		exp_q.push_back({m, v});
	endtask : note

	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			pv <= 1'b1;
			pd <= b[i];
			pl <= (i == b.size() - 1);
			tick(1);
		end
		pv <= 1'b0;
		pl <= 1'b0;
		tick(4);
	endtask : send

	task automatic rd(input logic [4:0] i, input logic [31:0] m, v);
		dr <= 1'b1;
		di <= i;
		note(m, v);
		tick(1);
		dr <= 1'b0;
		tick(4);
	endtask : rd

	task automatic cfg(input logic [5:0] i, o, input logic b, input logic [3:0] n);
		cv <= 1'b1;
		ci <= i;
		co <= o;
		cb <= b;
		tick(1);
		cv <= 1'b0;
		rd(5'h08, 32'hF0, {24'h0, n, 4'h0});
	endtask : cfg

	task automatic chk_now(input logic s, input logic [31:0] v);
		csel <= s;
		chk <= 1'b1;
		note(32'hFFFF_FFFF, v);
		tick(1);
		chk <= 1'b0;
		tick(1);
	endtask : chk_now

	// Expected diag byte as {mask, value}
	function automatic logic [15:0] ed(input int i, input logic prm);
		if (i == 0) ed = {8'hFF, sf[5], 2'b00, sf[4], 1'b1, 1'b0, ~prm, 1'b0};
		else if (i == 1) ed = {8'hFF, 2'b00, sf[3:1], 1'b1, sf[0], ~prm};
		else if (i == 3) ed = {8'hFF, prm ? ma : 8'hFF};
		else if (i == 4 || i == 5 || i == 8) ed = 16'h0000;
		else if (i == 6) ed = {8'hFF, lng ? 8'h0E : 8'h0A};
		else if (i == 7) ed = {8'hFF, 7'h00, mof};
		else if (i == 9) ed = {8'hFF, tof};
		else if (i == 10) ed = {8'hFF, tnr};
		else if (i == 11) ed = {8'hFF, tcf};
		else if (i >= 12 && i < (lng ? 20 : 16)) ed = {8'hFF, sw[8 * (i - 12) +: 8]};
		else ed = 16'hFF00;
	endfunction : ed

	// Expected process image per mode
	function automatic logic [31:0] map(input fpd_map_t m, input logic [31:0] r);
		map = 32'h0;
		for (int j = 0; j < 32; j++) begin
			if (m == FPD_MAP_NORMAL) map[j] = r[j];
			if (m == FPD_MAP_SHIFTED) map[16 * (j / 16) + 8 * (j % 2) + (j % 16) / 2] = r[j];
			if (m == FPD_MAP_HALVED && j < 16) map[j] = r[2 * j + 1];
		end
	endfunction : map

	// Full diag read-out, short then long
	task automatic sweep(input logic prm);
		for (int l = 0; l < 2; l++) begin
			{lng, mof} <= {l[0], l[0]};
			{sf, tnr, tcf, tof} <= 30'($urandom());
			sw <= {$urandom(), $urandom()};
			tick(2);
			for (int i = 0; i < 21; i++) begin
				dr <= 1'b1;
				di <= 5'(i);
				e = ed(i, prm);
				note({24'h0, e[15:8]}, {24'h0, e[7:0]});
				tick(1);
			end
			dr <= 1'b0;
			tick(5);
		end
	endtask : sweep

	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	initial begin
		repeat (30000) @(posedge mclk_i);
		n_errors++;
		$display("BAD %0t run limit", $time);
		conclude();
	end

	// Main sequence
	initial begin
		void'($urandom(32'hF22C));
		ma <= 8'($urandom());
		tick(2);
		nrst_i <= 1'b1;
		tick(2);
		chk_now(1'b1, 32'h43);
		cfg(6'h21, 6'h00, 1'b0, 4'h1);
		cfg(6'h08, 6'h19, 1'b0, 4'h2);
		cfg(6'h21, 6'h19, 1'b0, 4'h1);
		cfg(6'h1F, 6'h18, 1'b0, 4'h3);
		cfg(6'h20, 6'h17, 1'b0, 4'h4);
		cfg(6'h20, 6'h18, 1'b1, 4'h5);
		cfg(6'h20, 6'h18, 1'b0, 4'h0);
		sweep(1'b0);
		note(32'hFFFF_FFFF, 32'h4200_2010);
		send('{8'h0F, 8'h02, 8'h10, 8'h20});
		sweep(1'b1);
		t = '{8'h0F, 8'h07};
		for (int k = 0; k < 7; k++) t.push_back(ok_id[$urandom_range(7)]);
		note(32'hCF00_FFFF, {8'h47, 8'h00, t[3], t[2]});
		send(t);
		foreach (ok_id[k]) send('{8'h0F, 8'h01, ok_id[k] ^ 8'h04});
		send('{8'h0F, 8'h03, 8'h10, 8'h20});
		send('{8'h0F, 8'h08, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10});
		rd(5'h08, 32'h0F, 32'h03);
		note(32'hC000_0000, 32'h8000_0000);
		send('{8'h0E});
		chk_now(1'b1, 32'h43);
		for (int m = 2; m >= 0; m--) begin
			send('{8'(m)});
			rep <= $urandom();
			tick(8);
			chk_now(1'b0, map(fpd_map_t'(m[1:0]), rep));
		end
		fen <= 1'b1;
		tick(20);
		r1 = rep;
		rep <= ~r1;
		tick(5);
		rep <= r1;
		tick(20);
		chk_now(1'b0, r1);
		rep <= ~r1;
		tick(4);
		chk_now(1'b0, r1);
		tick(20);
		chk_now(1'b0, ~r1);
		tick(6);
		if (exp_q.size() != 0) begin
			n_errors++;
			$display("BAD %0t results missing", $time);
		end
		conclude();
	end
endmodule : tb_top
`default_nettype wire

// [core/fpd_filter.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fpd_consts.svh"
module fpd_filter import fpd_pkg::*; #(
	parameter int WIDTH = 32,
	parameter int FILT_CYC = `FPD_FILT_CYC
) (
	input  wire logic             mclk_i,
	input  wire logic             nrst_i,
	input  wire logic             enable_i,
	input  wire logic [WIDTH-1:0] raw_i,
	output logic      [WIDTH-1:0] clean_o
);
	typedef struct packed {
		logic [WIDTH-1:0]       clean;
		logic [WIDTH-1:0][16:0] cnt;
	} fpd_filt_st_t;
	fpd_filt_st_t st;
	fpd_filt_st_t next_st;

	// Per input: change taken once stable for the filter time
	always_comb begin
		next_st = st;
		for (int i = 0; i < WIDTH; i++) begin
			if (!enable_i || raw_i[i] == st.clean[i]) begin
				next_st.cnt[i] = '0;
				next_st.clean[i] = raw_i[i];
			end else if (st.cnt[i] >= 17'(FILT_CYC - 1)) begin
				// RULE6 accept after stable
				next_st.clean[i] = raw_i[i];
				next_st.cnt[i] = '0;
			end else begin
				next_st.cnt[i] = st.cnt[i] + 17'h00001;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign clean_o = st.clean;
endmodule : fpd_filter
`default_nettype wire

// [core/fpd_master.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fpd_consts.svh"
module fpd_master import fpd_pkg::*; (
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	fpd_if.master           bus,
	input  wire logic       prm_valid_i,
	input  wire logic [7:0] prm_data_i,
	input  wire logic       prm_last_i,
	input  wire logic       cfg_valid_i,
	input  wire logic [5:0] cfg_in_i,
	input  wire logic [5:0] cfg_out_i,
	input  wire logic       cfg_bad_i,
	input  wire logic       diag_req_i,
	input  wire logic [4:0] diag_idx_i,
	output logic [7:0]      diag_data_o,
	output logic [4:0]      diag_len_o,
	output logic [31:0]     in_image_o
);
	typedef struct packed {
		logic        pv;
		logic [7:0]  pd;
		logic        pl;
		logic        cv;
		logic [5:0]  ci;
		logic [5:0]  co;
		logic        cb;
		logic        dr;
		logic [4:0]  di;
		logic [7:0]  dd;
		logic [4:0]  dl;
		logic [31:0] img;
	} fpd_mst_st_t;
	fpd_mst_st_t st;
	fpd_mst_st_t next_st;

	// RULE1 RULE7 RULE9 RULE10 user side sends telegrams; RULE11 diagnosis read
	always_comb begin
		next_st = st;
		next_st.pv = prm_valid_i;
		next_st.pd = prm_data_i;
		next_st.pl = prm_last_i;
		next_st.cv = cfg_valid_i;
		next_st.ci = cfg_in_i;
		next_st.co = cfg_out_i;
		next_st.cb = cfg_bad_i;
		next_st.dr = diag_req_i;
		next_st.di = diag_idx_i;
		next_st.dd = bus.diag_data;
		next_st.dl = bus.diag_len;
		next_st.img = bus.in_image;
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bus.prm_valid = st.pv;
	assign bus.prm_data = st.pd;
	assign bus.prm_last = st.pl;
	assign bus.cfg_valid = st.cv;
	assign bus.cfg_in_cnt = st.ci;
	assign bus.cfg_out_cnt = st.co;
	assign bus.cfg_bad_byte = st.cb;
	assign bus.diag_req = st.dr;
	assign bus.diag_idx = st.di;
	assign diag_data_o = st.dd;
	assign diag_len_o = st.dl;
	assign in_image_o = st.img;
endmodule : fpd_master
`default_nettype wire

// [core/fpd_slave.sv]
// Operation
// RULE1: Map inputs by parameter-selected mode
// RULE2: Normal mode: inputs in sequence
// RULE3: Shifted: first sixteen alternate bytes 0/1
// RULE4: Shifted: next sixteen alternate bytes 2/3
// RULE5: Halved: only odd inputs, two bytes
// RULE6: Filter accepts changes lasting two milliseconds
// RULE7: Code 0x0E erases stored default
// RULE8: Defaults give four in, three out
// RULE9: Code 0x0F stores up to seven identifiers
// RULE10: Only permitted identifiers accepted
// RULE11: Diagnosis always ready for reading
// RULE12: Ten or fourteen byte extended block
// RULE13: Report configuration and parameter error numbers
// RULE14: Report failed extension terminals
// RULE15: Report configured terminals and switches
// RULE16: Standard byte 0 flags, two zeros
// RULE17: Byte 1 bit 2 one; master address
// RULE18: Configuration error numbers one to five
// RULE19: Overlong parameter telegram gives error 3
// RULE20: Missing-signal bit per extension terminal
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_consts.svh"
module fpd_slave import fpd_pkg::*; #(
	parameter int FILT_CYC = `FPD_FILT_CYC,
	parameter int MAX_PRM  = 9
) (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	fpd_if.slave             bus,
	input  wire logic [31:0] repeater_i,
	input  wire logic        filter_en_i,
	input  wire logic [7:0]  term_no_response_i,
	input  wire logic [7:0]  term_configured_i,
	input  wire logic [7:0]  term_out_fail_i,
	input  wire logic        main_out_fail_i,
	input  wire logic [63:0] term_switch_i,
	input  wire logic        long_diag_i,
	input  wire logic [7:0]  master_addr_i,
	input  wire logic [5:0]  std_flags_i,
	output logic             nv_erase_o,
	output logic             nv_write_o,
	output logic [3:0]       def_in_bytes_o,
	output logic [3:0]       def_out_bytes_o,
	output logic [7:0][7:0]  def_ids_o,
	output logic [3:0]       def_id_cnt_o
);
	typedef struct packed {
		fpd_pstate_t     ps;
		fpd_map_t        mode;
		logic [3:0]      pcnt;
		logic [3:0]      id_cnt;
		logic [7:0][7:0] ids;
		logic [7:0][7:0] def_ids;
		logic [3:0]      def_cnt;
		logic [3:0]      def_in;
		logic [3:0]      def_out;
		logic            bad_id;
		logic            is_def;
		logic            erase;
		logic            nv_wr;
		logic [3:0]      prm_err;
		logic [3:0]      cfg_err;
		logic            parameterized;
		logic [7:0]      mst_addr;
		logic [31:0]     image;
		logic [7:0]      diag_data;
		logic [4:0]      diag_len;
	} fpd_slv_st_t;
	fpd_slv_st_t st;
	fpd_slv_st_t next_st;
	logic [31:0] clean;
	// Identity bytes of the standard diagnosis
	localparam logic [7:0] IDENT_HI = 8'h5A; // Arbitrary value
	localparam logic [7:0] IDENT_LO = 8'hA5; // Arbitrary value

	// RULE6 debounce filter
	fpd_filter #(.WIDTH(32), .FILT_CYC(FILT_CYC)) u_filt (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.enable_i(filter_en_i),
		.raw_i   (repeater_i),
		.clean_o (clean)
	);

	function automatic logic id_ok(input logic [7:0] id);
		// RULE10 permitted identifiers
		id_ok = (id == `FPD_ID_PLACEHOLDER) || (id >= `FPD_ID_IN_LO && id <= `FPD_ID_IN_HI)
			|| (id >= `FPD_ID_OUT_LO && id <= `FPD_ID_OUT_HI);
	endfunction : id_ok

	function automatic logic [31:0] map_image(input fpd_map_t m, input logic [31:0] x);
		logic [31:0] r;
		r = '0;
		case (m)
			FPD_MAP_SHIFTED: begin
				// RULE3 RULE4 alternate byte pairs
				for (int k = 0; k < 8; k++) begin
					r[k]      = x[2*k];
					r[8+k]    = x[2*k+1];
					r[16+k]   = x[16+2*k];
					r[24+k]   = x[16+2*k+1];
				end
			end
			FPD_MAP_HALVED: begin
				// RULE5 odd inputs only
				for (int k = 0; k < 16; k++) begin
					r[k] = x[2*k+1];
				end
			end
			default: begin
				// RULE2 sequential order
				r = x;
			end
		endcase
		map_image = r;
	endfunction : map_image

	function automatic logic [7:0] diag_byte(input fpd_slv_st_t s, input logic [4:0] i);
		logic [7:0] b;
		logic [2:0] t;
		b = 8'h00;
		t = 3'(i - 5'h0C);
		if (i == 5'h00) begin
			// RULE16 byte 0 flags
			b = {std_flags_i[5], s.prm_err != 4'h0, 1'b0, std_flags_i[4], 1'b1,
				s.cfg_err != 4'h0, !s.parameterized, 1'b0};
		end else if (i == 5'h01) begin
			// RULE17 fixed one, mode bits
			b = {2'b00, std_flags_i[3:1], 1'b0, std_flags_i[0], !s.parameterized};
			b[`FPD_STAT1_FIXED] = 1'b1;
		end else if (i == 5'h03) begin
			// RULE17 master address
			b = s.parameterized ? s.mst_addr : `FPD_NO_MASTER;
		end else if (i == 5'h04) begin
			b = IDENT_HI;
		end else if (i == 5'h05) begin
			b = IDENT_LO;
		end else if (i == 5'h06) begin
			// RULE12 header states length
			b = {3'b000, long_diag_i ? `FPD_EXT_LEN_LONG : `FPD_EXT_LEN_SHORT};
		end else if (i == 5'h07) begin
			b = {7'h00, main_out_fail_i};
		end else if (i == 5'h08) begin
			// RULE13 error numbers
			b = {s.cfg_err, s.prm_err};
		end else if (i == 5'h09) begin
			b = term_out_fail_i;
		end else if (i == 5'h0A) begin
			// RULE14 RULE20 missing-signal bits
			b = term_no_response_i;
		end else if (i == 5'h0B) begin
			// RULE15 configured terminals
			b = term_configured_i;
		end else if (i >= 5'h0C && i < (long_diag_i ? 5'h14 : 5'h10)) begin
			// RULE15 switch settings
			b = term_switch_i[8*t +: 8];
		end
		diag_byte = b;
	endfunction : diag_byte

	// Parameter interpreter, configuration check and diagnosis
	always_comb begin
		next_st = st;
		next_st.erase = 1'b0;
		next_st.nv_wr = 1'b0;
		if (bus.prm_valid) begin
			case (st.ps)
				FPD_PS_IDLE: begin
					next_st.pcnt = 4'h1;
					next_st.bad_id = 1'b0;
					next_st.id_cnt = 4'h0;
					next_st.ids = '0;
					next_st.is_def = (bus.prm_data == `FPD_CODE_NEWDEF);
					next_st.ps = bus.prm_last ? FPD_PS_IDLE : FPD_PS_BODY;
					next_st.parameterized = 1'b1;
					next_st.mst_addr = master_addr_i;
					next_st.prm_err = 4'h0;
					if (bus.prm_data == `FPD_CODE_ERASE) begin
						// RULE7 erase stored default
						next_st.erase = bus.prm_last;
						next_st.def_in = 4'(`FPD_DEF_IN_BYTES);
						next_st.def_out = 4'(`FPD_DEF_OUT_BYTES);
						next_st.def_cnt = 4'h0;
					end else if (bus.prm_data != `FPD_CODE_NEWDEF) begin
						// RULE1 mode from telegram
						next_st.mode = fpd_map_t'(bus.prm_data[`FPD_MODE_LSB +: 2]);
					end
				end
				FPD_PS_BODY: begin
					next_st.pcnt = st.pcnt + 4'h1;
					if (st.pcnt >= 4'(MAX_PRM)) begin
						// RULE19 overlong telegram
						next_st.prm_err = `FPD_PRM_ERR_LONG;
					end else if (st.is_def && st.pcnt == 4'h1) begin
						next_st.id_cnt = bus.prm_data[3:0];
						if (bus.prm_data > 8'(`FPD_MAX_IDS)) begin
							next_st.bad_id = 1'b1;
						end
					end else if (st.is_def) begin
						next_st.ids[3'(st.pcnt - 4'h2)] = bus.prm_data;
						if (!id_ok(bus.prm_data)) begin
							next_st.bad_id = 1'b1;
						end
					end
					if (bus.prm_last) begin
						next_st.ps = FPD_PS_CHECK;
					end
				end
				default: ;
			endcase
		end
		if (st.ps == FPD_PS_CHECK) begin
			next_st.ps = FPD_PS_IDLE;
			if (st.is_def && !st.bad_id && st.prm_err == 4'h0
				&& st.pcnt == st.id_cnt + 4'h2) begin
				// RULE9 store new default
				next_st.def_ids = st.ids;
				next_st.def_cnt = st.id_cnt;
				next_st.nv_wr = 1'b1;
			end
		end
		if (bus.cfg_valid) begin
			// RULE18 configuration error numbers
			if (bus.cfg_in_cnt > `FPD_MAX_TERM_IN) begin
				next_st.cfg_err = `FPD_CFG_ERR_IN;
			end else if (bus.cfg_out_cnt > `FPD_MAX_TERM_OUT) begin
				next_st.cfg_err = `FPD_CFG_ERR_OUT;
			end else if (bus.cfg_in_cnt < 6'({st.def_in, 3'b000})) begin
				next_st.cfg_err = `FPD_CFG_ERR_FEWIN;
			end else if (bus.cfg_out_cnt < 6'({st.def_out, 3'b000})) begin
				next_st.cfg_err = `FPD_CFG_ERR_FEWOUT;
			end else if (bus.cfg_bad_byte) begin
				next_st.cfg_err = `FPD_CFG_ERR_BYTE;
			end else begin
				next_st.cfg_err = 4'h0;
			end
		end
		// RULE1 image in selected mode
		next_st.image = map_image(st.mode, clean);
		// RULE11 diagnosis answered every read
		if (bus.diag_req) begin
			next_st.diag_data = diag_byte(st, bus.diag_idx);
		end
		// RULE12 total length
		next_st.diag_len = `FPD_STD_DIAG_LEN + (long_diag_i ? `FPD_EXT_LEN_LONG : `FPD_EXT_LEN_SHORT);
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
			// RULE8 default image size
			st.def_in <= 4'(`FPD_DEF_IN_BYTES);
			st.def_out <= 4'(`FPD_DEF_OUT_BYTES);
		end else begin
			st <= next_st;
		end
	end

	assign bus.diag_data = st.diag_data;
	assign bus.diag_len = st.diag_len;
	assign bus.in_image = st.image;
	assign nv_erase_o = st.erase;
	assign nv_write_o = st.nv_wr;
	assign def_in_bytes_o = st.def_in;
	assign def_out_bytes_o = st.def_out;
	assign def_ids_o = st.def_ids;
	assign def_id_cnt_o = st.def_cnt;
endmodule : fpd_slave
`default_nettype wire

// [pkg/fpd_consts.svh]
`ifndef FPD_CONSTS_SVH
`define FPD_CONSTS_SVH
// User parameter codes
`define FPD_CODE_ERASE      8'h0E
`define FPD_CODE_NEWDEF     8'h0F
`define FPD_MAX_IDS         4'h7
// Identifier ranges
`define FPD_ID_PLACEHOLDER  8'h00
`define FPD_ID_IN_LO        8'h10
`define FPD_ID_IN_HI        8'h13
`define FPD_ID_OUT_LO       8'h20
`define FPD_ID_OUT_HI       8'h22
// Default image size
`define FPD_DEF_IN_BYTES    3'h4
`define FPD_DEF_OUT_BYTES   3'h3
// Mapping mode field of user parameter byte 0 when not a special code
`define FPD_MODE_LSB        0
// Diagnosis layout
`define FPD_STD_DIAG_LEN    5'h06
`define FPD_EXT_LEN_SHORT   5'h0A
`define FPD_EXT_LEN_LONG    5'h0E
`define FPD_NO_MASTER       8'hFF
`define FPD_STAT1_FIXED     2
// Error numbers
`define FPD_CFG_ERR_IN      4'h1
`define FPD_CFG_ERR_OUT     4'h2
`define FPD_CFG_ERR_FEWIN   4'h3
`define FPD_CFG_ERR_FEWOUT  4'h4
`define FPD_CFG_ERR_BYTE    4'h5
`define FPD_PRM_ERR_LONG    4'h3
`define FPD_MAX_TERM_IN     6'h20
`define FPD_MAX_TERM_OUT    6'h18
// Filter time
`define FPD_FILT_US         2000
`define FPD_CLK_MHZ         25
`define FPD_FILT_CYC        (`FPD_FILT_US * `FPD_CLK_MHZ)
`endif

// [pkg/fpd_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface fpd_if;
	// Parameter telegram stream, master to slave
	logic       prm_valid;
	logic [7:0] prm_data;
	logic       prm_last;
	// Configuration result, master to slave
	logic       cfg_valid;
	logic [5:0] cfg_in_cnt;
	logic [5:0] cfg_out_cnt;
	logic       cfg_bad_byte;
	// Diagnosis read
	logic       diag_req;
	logic [4:0] diag_idx;
	logic [7:0] diag_data;
	logic [4:0] diag_len;
	// Process image
	logic [31:0] in_image;
	modport slave (input prm_valid, prm_data, prm_last, cfg_valid, cfg_in_cnt, cfg_out_cnt, cfg_bad_byte,
		diag_req, diag_idx, output diag_data, diag_len, in_image);
	modport master (output prm_valid, prm_data, prm_last, cfg_valid, cfg_in_cnt, cfg_out_cnt, cfg_bad_byte,
		diag_req, diag_idx, input diag_data, diag_len, in_image);
endinterface : fpd_if
`default_nettype wire

// [pkg/fpd_pkg.sv]
package fpd_pkg;
	typedef enum logic [1:0] {FPD_MAP_NORMAL, FPD_MAP_SHIFTED, FPD_MAP_HALVED, FPD_MAP_RSVD} fpd_map_t;
	typedef enum logic [1:0] {FPD_PS_IDLE, FPD_PS_BODY, FPD_PS_CHECK} fpd_pstate_t;
	typedef logic [7:0] fpd_byte_t;
endpackage : fpd_pkg
